// File: pkg/gp_regs.svh
`ifndef GP_REGS_SVH
`define GP_REGS_SVH

// Register map, byte addresses on the APB side
`define GP_NPORT 2
`define GP_PORT_STRIDE 12'h010
`define GP_OFF_VALUE 12'h000
`define GP_OFF_IRQEN 12'h004
`define GP_OFF_DM_LOW 12'h008
`define GP_OFF_DM_HIGH 12'h00c
`define GP_OFF_IO_CONFIG_ONE 12'h0dc
`define GP_OFF_OUT_SEL 12'h0e0
`define GP_OFF_GIRQ 12'h0e4

// Reset values
`define GP_RST_VALUE 8'h00
`define GP_RST_IRQEN 8'h00
`define GP_RST_DM_LOW 8'h00
`define GP_RST_DM_HIGH 8'hff
`define GP_RST_IO_CONFIG_ONE 8'h00
`define GP_RST_OUT_SEL 4'h0
`define GP_RST_GIRQ 1'b0

// io_config_one fields
`define GP_CFG_STRONG 7
`define GP_CFG_RANGE_HI 5
`define GP_CFG_RANGE_LO 4
`define GP_CFG_LOW_THR 3
`define GP_CFG_SPI_MAP 2
`define GP_CFG_REG_EN 1
`define GP_CFG_IRQ_MODE 0
`define GP_CFG_RW_MASK 8'hbf

// Port layout and serial pin map
`define GP_SER_PORT 1
`define GP_PIN_MASK_FULL 8'hff
`define GP_PIN_MASK_SER 8'h0f
`define GP_SPI_PIN_ALT 8'h01
`define GP_SPI_PIN_DEF 8'h08
`define GP_I2C_PINS 8'h06
`define GP_OUT_SEL_W 4

`endif

// File: pkg/gp_pkg.sv
package gp_pkg;

    typedef enum logic [1:0] {
        GP_DM_PULLUP,
        GP_DM_STRONG,
        GP_DM_ANALOG,
        GP_DM_OPEN_DRAIN
    } gp_drive_mode_t;

    typedef enum logic [1:0] {
        GP_LVL_3V0,
        GP_LVL_1V8,
        GP_LVL_2V5
    } gp_reg_level_t;

    // Per-port pad control, one bit per pin
    typedef struct packed {
        logic [7:0] drvOut;
        logic [7:0] oeN;
        logic [7:0] pullUpEn;
        logic [7:0] inEn;
    } gp_pad_t;

    // Port 1 supply and buffer settings
    typedef struct packed {
        logic regEn;
        gp_reg_level_t level;
        logic lowThreshold;
        logic strongHigh;
    } gp_p1cfg_t;

endpackage : gp_pkg

// File: src/gp_port_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "gp_regs.svh"

// How it works
// [RL1] Enabling SPI or I2C bypasses that function's pins automatically.
// [RL2] A set port1_output_select bit routes the internal signal to its pin.
// [RL3] Bypass leaves drive mode alone; software sets it in both registers.
// [RL4] Software writes zero to reserved bits.
// [RL5] Registers read back stored values; port_pin_value reads the pins.
// [RL6] A port_pin_value bit drives its pin high or low unless bypassed.
// [RL7] port_irq_enable bits gate pin interrupts; four-pin port uses low four.
// [RL8] Pin drive mode joins same-numbered high and low drive-mode bits.
// [RL9] Modes: 00 pull-up, 01 strong, 10 analog high-Z, 11 open drain.
// [RL10] Analog mode disables the digital input; pin reads zero, no interrupt.
// [RL11] Reset loads high drive-mode registers with ones, low with zeros.
// [RL12] Range field picks port 1 level: 00/01 3.0 V, 10 1.8 V, 11 2.5 V.
// [RL13] Regulator enable bit turns the port 1 output regulator on.
// [RL14] Low-threshold bit selects reduced port 1 input thresholds.
// [RL15] Clock map bit one puts SPI clock on pin 0, else pin 3.
// [RL16] One interrupt mode for all pins; global mask gates the request.
// [RL17] Strong drive bit selects increased high drive strength.
// [RL18] Mode zero: enabled pin interrupts while its level is low.
// [RL19] Mode one: enabled pin interrupts while level differs from last read.
// [RL20] Pin holds the line until enable, level, read latch or mode changes.
// [RL21] All pin interrupts merge into one active-low request.
// [RL22] Pin mux picks bypass data when selected, else port_pin_value.
module gp_port_ctrl (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] padIn [`GP_NPORT],
    output gp_pkg::gp_pad_t padCtl [`GP_NPORT],
    input wire logic [7:0] altData [`GP_NPORT],
    input wire logic spiEnable,
    input wire logic spiClk,
    input wire logic i2cEnable,
    input wire logic i2cSclOut,
    input wire logic i2cSdaOut,
    output gp_pkg::gp_p1cfg_t port1Cfg,
    output logic gpioIrqLineN,
    output logic gpioIrqReqN
);

    logic [7:0] cfgFf;
    logic [`GP_OUT_SEL_W-1:0] outSelFf;
    logic girqFf;
    logic [31:0] prdataFf;
    gp_pkg::gp_p1cfg_t p1CfgFf;
    logic irqLineNFf;
    logic irqReqNFf;

    logic [7:0] portRd [`GP_NPORT];
    logic [`GP_NPORT-1:0] portHit;
    logic [`GP_NPORT-1:0] portIrq;
    logic [7:0] rdMux;
    logic anyHit;

    function automatic logic isPortReg(
        input logic [11:0] addr,
        input int port,
        input logic [11:0] off
    );
        logic [11:0] base;
        base = 12'(port) * `GP_PORT_STRIDE;
        return addr == (base + off);
    endfunction : isPortReg

    wire setupPh = psel & ~penable;
    wire accessPh = psel & penable;
    wire wrTake = accessPh & pwrite & pstrb[0] & anyHit;
    wire rdTake = accessPh & ~pwrite & anyHit;

    wire hitCfg = paddr == `GP_OFF_IO_CONFIG_ONE;
    wire hitOutSel = paddr == `GP_OFF_OUT_SEL;
    wire hitGirq = paddr == `GP_OFF_GIRQ;
    wire hitGlobal = hitCfg | hitOutSel | hitGirq;

    wire irqMode = cfgFf[`GP_CFG_IRQ_MODE]; // RL16
    wire spiMap = cfgFf[`GP_CFG_SPI_MAP];

    // Hard-wired serial bypass, only on the serial port
    wire [7:0] spiPin = spiMap ? `GP_SPI_PIN_ALT : `GP_SPI_PIN_DEF; // RL15
    wire [7:0] spiByp = spiEnable ? spiPin : 8'h00; // RL1
    wire [7:0] i2cByp = i2cEnable ? `GP_I2C_PINS : 8'h00; // RL1
    wire [7:0] hwByp = spiByp | i2cByp;
    wire [7:0] spiVal = spiClk ? spiByp : 8'h00;
    wire [7:0] i2cVal = {5'h00, i2cSdaOut, i2cSclOut, 1'b0} & i2cByp;
    wire [7:0] hwAlt = spiVal | i2cVal;
    wire [7:0] userByp = {{(8-`GP_OUT_SEL_W){1'b0}}, outSelFf}; // RL2

    wire [7:0] cfgWr = pwdata[7:0] & `GP_CFG_RW_MASK;

    // Range 00 and 01 both mean 3.0 V
    wire [1:0] rangeSel = {cfgFf[`GP_CFG_RANGE_HI], cfgFf[`GP_CFG_RANGE_LO]};
    gp_pkg::gp_reg_level_t levelW;
    assign levelW = (rangeSel == 2'h2) ? gp_pkg::GP_LVL_1V8 :
                    (rangeSel == 2'h3) ? gp_pkg::GP_LVL_2V5 :
                    gp_pkg::GP_LVL_3V0; // RL12

    gp_pkg::gp_p1cfg_t nxt_p1Cfg;
    assign nxt_p1Cfg.regEn = cfgFf[`GP_CFG_REG_EN]; // RL13
    assign nxt_p1Cfg.level = levelW;
    assign nxt_p1Cfg.lowThreshold = cfgFf[`GP_CFG_LOW_THR]; // RL14
    assign nxt_p1Cfg.strongHigh = cfgFf[`GP_CFG_STRONG]; // RL17

    for (genvar p = 0; p < `GP_NPORT; p++) begin : gPort
        localparam logic [7:0] PIN_MASK = (p == `GP_SER_PORT) ?
            `GP_PIN_MASK_SER : `GP_PIN_MASK_FULL;
        localparam logic SER = (p == `GP_SER_PORT);

        logic [7:0] valueFf;
        logic [7:0] ieFf;
        logic [7:0] dmLoFf;
        logic [7:0] dmHiFf;
        logic [7:0] latchFf;
        logic [7:0] syncAFf;
        logic [7:0] syncBFf;
        gp_pkg::gp_pad_t padFf;
        gp_pkg::gp_pad_t nxt_pad;

        wire hitV = isPortReg(paddr, p, `GP_OFF_VALUE);
        wire hitIe = isPortReg(paddr, p, `GP_OFF_IRQEN);
        wire hitLo = isPortReg(paddr, p, `GP_OFF_DM_LOW);
        wire hitHi = isPortReg(paddr, p, `GP_OFF_DM_HIGH);

        // Bypass selection touches data only, never the drive mode
        wire [7:0] bypSel = SER ? (hwByp | userByp) : 8'h00; // RL3
        wire [7:0] altVal = SER ? ((altData[p] & ~hwByp) | hwAlt) :
                            altData[p];
        wire [7:0] pinData = (bypSel & altVal) |
                             (~bypSel & valueFf); // RL22 RL6

        // Analog mode kills the input buffer
        wire [7:0] inEnW = ~(dmHiFf & ~dmLoFf); // RL10
        wire [7:0] pinLvl = syncBFf & inEnW; // RL10

        // Mode one compares with the level latched at the last read
        wire [7:0] irqCond = irqMode ? (pinLvl ^ latchFf) :
                             ~pinLvl; // RL18 RL19
        wire [7:0] pinIrq = ieFf & PIN_MASK & inEnW & irqCond; // RL7 RL20

        assign portIrq[p] = |pinIrq; // RL21
        assign portHit[p] = hitV | hitIe | hitLo | hitHi;
        assign portRd[p] = hitV ? pinLvl : // RL5
                           hitIe ? ieFf :
                           hitLo ? dmLoFf :
                           hitHi ? dmHiFf : 8'h00;

        for (genvar i = 0; i < 8; i++) begin : gPin
            gp_pkg::gp_drive_mode_t mode;
            assign mode = gp_pkg::gp_drive_mode_t'(
                {dmHiFf[i], dmLoFf[i]}); // RL8

            always_comb begin
                nxt_pad.inEn[i] = inEnW[i];
                nxt_pad.pullUpEn[i] = 1'b0;
                nxt_pad.drvOut[i] = 1'b0;
                nxt_pad.oeN[i] = 1'b1;
                case (mode) // RL9
                    gp_pkg::GP_DM_PULLUP: begin
                        nxt_pad.pullUpEn[i] = pinData[i];
                        nxt_pad.oeN[i] = pinData[i];
                    end
                    gp_pkg::GP_DM_STRONG: begin
                        nxt_pad.drvOut[i] = pinData[i];
                        nxt_pad.oeN[i] = 1'b0;
                    end
                    gp_pkg::GP_DM_ANALOG: begin
                        nxt_pad.oeN[i] = 1'b1;
                    end
                    gp_pkg::GP_DM_OPEN_DRAIN: begin
                        nxt_pad.oeN[i] = pinData[i];
                    end
                    default: begin
                        nxt_pad.oeN[i] = 1'b1;
                    end
                endcase
            end
        end

        // Pad levels come from another domain
        always_ff @(posedge mclk) begin
            if (reset) begin
                syncAFf <= 8'h00;
                syncBFf <= 8'h00;
            end else begin
                syncAFf <= padIn[p];
                syncBFf <= syncAFf;
            end
        end

        always_ff @(posedge mclk) begin
            if (reset) begin
                valueFf <= `GP_RST_VALUE;
                ieFf <= `GP_RST_IRQEN;
                dmLoFf <= `GP_RST_DM_LOW; // RL11
                dmHiFf <= `GP_RST_DM_HIGH; // RL11
            end else if (wrTake) begin
                if (hitV) begin
                    valueFf <= pwdata[7:0]; // RL6
                end
                if (hitIe) begin
                    ieFf <= pwdata[7:0]; // RL7
                end
                if (hitLo) begin
                    dmLoFf <= pwdata[7:0];
                end
                if (hitHi) begin
                    dmHiFf <= pwdata[7:0];
                end
            end
        end

        // A read re-arms change detection at the value just returned
        always_ff @(posedge mclk) begin
            if (reset) begin
                latchFf <= 8'h00;
            end else if (rdTake & hitV) begin
                latchFf <= prdataFf[7:0]; // RL19 RL20
            end
        end

        always_ff @(posedge mclk) begin
            if (reset) begin
                padFf <= '{drvOut: 8'h00, oeN: 8'hff,
                           pullUpEn: 8'h00, inEn: 8'h00};
            end else begin
                padFf <= nxt_pad;
            end
        end

        assign padCtl[p] = padFf;
    end

    always_comb begin
        rdMux = 8'h00;
        anyHit = hitGlobal;
        for (int p = 0; p < `GP_NPORT; p++) begin
            rdMux = rdMux | portRd[p];
            anyHit = anyHit | portHit[p];
        end
        if (hitCfg) begin
            rdMux = cfgFf;
        end else if (hitOutSel) begin
            rdMux = userByp;
        end else if (hitGirq) begin
            rdMux = {7'h00, girqFf};
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cfgFf <= `GP_RST_IO_CONFIG_ONE;
            outSelFf <= `GP_RST_OUT_SEL;
            girqFf <= `GP_RST_GIRQ;
        end else if (wrTake) begin
            if (hitCfg) begin
                cfgFf <= cfgWr;
            end
            if (hitOutSel) begin
                outSelFf <= pwdata[`GP_OUT_SEL_W-1:0]; // RL2
            end
            if (hitGirq) begin
                girqFf <= pwdata[0];
            end
        end
    end

    // Read data is captured in setup so the access phase needs no wait
    always_ff @(posedge mclk) begin
        if (reset) begin
            prdataFf <= 32'h0000_0000;
        end else if (setupPh) begin
            prdataFf <= {24'h00_0000, rdMux}; // RL5
        end
    end

    wire anyPinIrq = |portIrq; // RL21
    wire nxt_irqLineN = ~anyPinIrq;
    wire nxt_irqReqN = ~(anyPinIrq & girqFf); // RL16

    always_ff @(posedge mclk) begin
        if (reset) begin
            p1CfgFf <= '{regEn: 1'b0, level: gp_pkg::GP_LVL_3V0,
                         lowThreshold: 1'b0, strongHigh: 1'b0};
            irqLineNFf <= 1'b1;
            irqReqNFf <= 1'b1;
        end else begin
            p1CfgFf <= nxt_p1Cfg;
            irqLineNFf <= nxt_irqLineN;
            irqReqNFf <= nxt_irqReqN;
        end
    end

    assign prdata = prdataFf;
    assign pready = 1'b1;
    assign pslverr = accessPh & ~anyHit;
    assign port1Cfg = p1CfgFf;
    assign gpioIrqLineN = irqLineNFf;
    assign gpioIrqReqN = irqReqNFf;

endmodule : gp_port_ctrl

`default_nettype wire

// File: sim/gp_port_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "gp_regs.svh"
module gp_port_ctrl_props (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire gp_pkg::gp_pad_t padCtl [`GP_NPORT],
    input wire gp_pkg::gp_p1cfg_t port1Cfg,
    input wire logic gpioIrqLineN,
    input wire logic gpioIrqReqN
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire logic cfgWr = psel && penable && pwrite && pstrb[0]
        && paddr == `GP_OFF_IO_CONFIG_ONE;
    wire logic [1:0] expLvl = pwdata[5] ? (pwdata[4] ? 2'h2 : 2'h1) : 2'h0;
    wire logic [7:0] drvHiz = (~padCtl[0].inEn & ~padCtl[0].oeN)
        | (~padCtl[1].inEn & ~padCtl[1].oeN);
    wire logic [7:0] pullDrv = (padCtl[0].pullUpEn & ~padCtl[0].oeN)
        | (padCtl[1].pullUpEn & ~padCtl[1].oeN);
    AST_CFG_REGEN: assert property (cfgWr |-> ##2
        port1Cfg.regEn == $past(pwdata[1], 2)) else $error("regEn wrong");
    AST_CFG_THR: assert property (cfgWr |-> ##2
        port1Cfg.lowThreshold == $past(pwdata[3], 2)) else $error("thr wrong");
    AST_CFG_STRONG: assert property (cfgWr |-> ##2
        port1Cfg.strongHigh == $past(pwdata[7], 2)) else $error("strong");
    AST_CFG_LEVEL: assert property (cfgWr |-> ##2
        port1Cfg.level == $past(expLvl, 2)) else $error("level wrong");
    AST_RST_HIZ: assert property ($fell(reset) |->
        padCtl[0].oeN == 8'hff && padCtl[1].oeN == 8'hff)
        else $error("pins driven after reset");
    AST_HIZ_NODRIVE: assert property (drvHiz == 8'h00)
        else $error("analog pin driven");
    AST_PULLUP_REL: assert property (pullDrv == 8'h00)
        else $error("pull-up on a driven pin");
    AST_REQ_GATED: assert property (!gpioIrqReqN |-> !gpioIrqLineN)
        else $error("request without pin interrupt");
    AST_UNMAPPED: assert property (psel && penable && paddr == 12'h0f0
        |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    AST_RD_UPPER: assert property (psel && penable && !pwrite
        |-> pready && prdata[31:8] == 24'h0) else $error("read upper bits");
    COV_CFG: cover property (cfgWr);
    COV_REQ: cover property (!gpioIrqReqN);
    COV_REL: cover property ($rose(gpioIrqLineN));
endmodule : gp_port_ctrl_props
bind gp_port_ctrl gp_port_ctrl_props i_gp_port_ctrl_props (.mclk, .reset,
    .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .padCtl, .port1Cfg, .gpioIrqLineN, .gpioIrqReqN);
`default_nettype wire

// File: sim/gp_port_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "gp_regs.svh"
module gp_port_ctrl_test;
    logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0001_6625;
    logic [3:0] pstrb = 4'hf;
    logic [7:0] padIn [`GP_NPORT] = '{8'h5a, 8'hff};
    logic [7:0] altData [`GP_NPORT] = '{8'h00, 8'h00};
    logic spiEnable = 0, spiClk = 0, i2cEnable = 0;
    logic i2cSclOut = 0, i2cSdaOut = 0;
    logic pready, pslverr, gpioIrqLineN, gpioIrqReqN;
    gp_pkg::gp_pad_t padCtl [`GP_NPORT];
    gp_pkg::gp_p1cfg_t port1Cfg;
    logic [8:0] expQ [$];
    logic [8:0] e;
    int num_errors = 0, n_tests = 0;
    localparam logic [11:0] P1 = `GP_PORT_STRIDE;
    localparam logic [11:0] CFG = `GP_OFF_IO_CONFIG_ONE;
    always #2 mclk = ~mclk;
    gp_port_ctrl i_gp_port_ctrl (.mclk, .reset, .paddr, .psel, .penable,
        .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .padIn,
        .padCtl, .altData, .spiEnable, .spiClk, .i2cEnable, .i2cSclOut,
        .i2cSdaOut, .port1Cfg, .gpioIrqLineN, .gpioIrqReqN);
    task chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
        n_tests++;
        if (g !== ex) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, g);
        end
    endtask : chk
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task apb(input logic [11:0] a, input logic w, input logic [8:0] d);
        @(posedge mclk);
        psel <= 1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h0, d[7:0]};
        if (!w) expQ.push_back(d);
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, {1'b0, d});
    endtask : wr
    task rd(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b0, {1'b0, d});
    endtask : rd
    task st;
        repeat (6) @(posedge mclk);
        #1;
    endtask : st
    task pin(input int p, input logic [7:0] v);
        @(posedge mclk);
        padIn[p] <= v;
    endtask : pin
    task irq(input logic l, input logic q);
        st;
        chk("irqLine", 8'(l), 8'(gpioIrqLineN));
        chk("irqReq", 8'(q), 8'(gpioIrqReqN));
    endtask : irq
    // Results land at the access edge, before the master lets go
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = expQ.pop_front();
            chk("prdata", e[7:0], prdata[7:0]);
            chk("pslverr", 8'(e[8]), 8'(pslverr));
        end
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        end_of_test();
    end
    initial begin
        logic [7:0] r;
        repeat (16) @(posedge mclk);
        reset <= 0;
        for (int p = 0; p < 2; p++) begin
            rd(12'(p * 16), 8'h00);
            rd(12'(p * 16 + 4), 8'h00);
            rd(12'(p * 16 + 8), 8'h00);
            rd(12'(p * 16 + 12), 8'hff);
        end
        rd(CFG, 8'h00);
        rd(`GP_OFF_OUT_SEL, 8'h00);
        apb(12'h0f0, 1'b0, 9'h100);
        st;
        chk("oeN", 8'hff, padCtl[0].oeN);
        $display("test reset done");
        // Six read-write port registers; port 1 starts one stride up
        for (int k = 1; k < 7; k++) begin
            seed = xs(seed);
            r = seed[7:0];
            wr(12'(k * 4 + (k > 3 ? 4 : 0)), r);
            rd(12'(k * 4 + (k > 3 ? 4 : 0)), r);
        end
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            r = {seed[7], 1'b0, 2'(k), seed[3:0]};
            wr(CFG, r);
            rd(CFG, r);
            st;
            chk("p1cfg", {3'h0, r[1], k < 2 ? 2'h0 : 2'(k - 1), r[3], r[7]},
                {3'h0, port1Cfg});
        end
        // A write without its low strobe must leave the register alone
        @(posedge mclk);
        pstrb <= 4'he;
        wr(CFG, ~r & 8'hbf);
        @(posedge mclk);
        pstrb <= 4'hf;
        rd(CFG, r);
        $display("test registers done");
        wr(`GP_OFF_DM_HIGH, 8'h0c);
        wr(`GP_OFF_DM_LOW, 8'h0a);
        for (int k = 0; k < 2; k++) begin
            wr(`GP_OFF_VALUE, k ? 8'hff : 8'h00);
            st;
            chk("oeN", k ? 8'hfd : 8'h04, padCtl[0].oeN);
            chk("pullUp", k ? 8'hf1 : 8'h00, padCtl[0].pullUpEn);
            chk("inEn", 8'hfb, padCtl[0].inEn);
            chk("drv", k ? 8'h02 : 8'h00,
                padCtl[0].drvOut & ~padCtl[0].oeN);
        end
        seed = xs(seed);
        pin(0, seed[7:0]);
        st;
        rd(`GP_OFF_VALUE, seed[7:0] & 8'hfb);
        $display("test drive done");
        wr(P1 + `GP_OFF_DM_HIGH, 8'h00);
        wr(P1 + `GP_OFF_DM_LOW, 8'h0f);
        wr(P1 + `GP_OFF_VALUE, 8'h00);
        seed = xs(seed);
        @(posedge mclk);
        altData[1] <= seed[7:0];
        wr(`GP_OFF_OUT_SEL, 8'h0f);
        st;
        chk("bypass", {4'h0, seed[3:0]}, {4'h0, padCtl[1].drvOut[3:0]});
        rd(P1 + `GP_OFF_DM_LOW, 8'h0f);
        wr(`GP_OFF_OUT_SEL, 8'h00);
        st;
        chk("noBypass", 8'h00, {4'h0, padCtl[1].drvOut[3:0]});
        @(posedge mclk);
        i2cEnable <= 1;
        i2cSclOut <= 1;
        i2cSdaOut <= 1;
        st;
        chk("i2c", 8'h06, {4'h0, padCtl[1].drvOut[3:0]});
        @(posedge mclk);
        i2cEnable <= 0;
        spiEnable <= 1;
        spiClk <= 1;
        for (int k = 0; k < 2; k++) begin
            wr(CFG, 8'(k * 4));
            st;
            chk("spiClk", k ? 8'h01 : 8'h08,
                {4'h0, padCtl[1].drvOut[3:0]});
        end
        @(posedge mclk);
        spiClk <= 0;
        st;
        chk("spiLow", 8'h00, {4'h0, padCtl[1].drvOut[3:0]});
        @(posedge mclk);
        spiEnable <= 0;
        $display("test bypass done");
        wr(`GP_OFF_DM_HIGH, 8'h00);
        wr(`GP_OFF_DM_LOW, 8'h00);
        wr(`GP_OFF_VALUE, 8'hff);
        pin(0, 8'hff);
        pin(1, 8'h00);
        wr(CFG, 8'h00);
        wr(P1 + `GP_OFF_IRQEN, 8'hf0);
        wr(`GP_OFF_IRQEN, 8'h01);
        irq(1'b1, 1'b1);
        pin(0, 8'hfe);
        irq(1'b0, 1'b1);
        wr(`GP_OFF_GIRQ, 8'h01);
        irq(1'b0, 1'b0);
        wr(`GP_OFF_IRQEN, 8'h00);
        irq(1'b1, 1'b1);
        wr(CFG, 8'h01);
        wr(`GP_OFF_IRQEN, 8'h01);
        rd(`GP_OFF_VALUE, 8'hfe);
        irq(1'b1, 1'b1);
        pin(0, 8'hff);
        irq(1'b0, 1'b0);
        rd(`GP_OFF_VALUE, 8'hff);
        irq(1'b1, 1'b1);
        wr(CFG, 8'h00);
        wr(P1 + `GP_OFF_IRQEN, 8'h01);
        irq(1'b0, 1'b0);
        $display("test interrupts done");
        end_of_test();
    end
endmodule : gp_port_ctrl_test
`default_nettype wire
